// file: logic/ato_map.svh
`ifndef ATO_MAP_SVH
`define ATO_MAP_SVH

// Register byte offsets.
`define ATO_CTRL_OFS 4'h0
`define ATO_MODE_ONE_OFS 4'h4
`define ATO_MODE_FIVE_OFS 4'h8
`define ATO_STATUS_OFS 4'hC

// Field positions.
`define ATO_CTRL_DLL_OFF_BIT 0
`define ATO_CTRL_WR_TERM_BIT 1
`define ATO_NOM_LSB 8
`define ATO_PARK_LSB 6
`define ATO_ST_PIN_BIT 8
`define ATO_ST_WRT_BIT 9

// Reset values.
`define ATO_CTRL_RST 2'b01
`define ATO_CODE_RST 3'h0

// Clock period and window times in picoseconds.
`define ATO_CLK_PERIOD_PS 25000
`define ATO_ON_MIN_PS 1000
`define ATO_ON_MAX_PS 9000
`define ATO_OFF_MIN_PS 1000
`define ATO_OFF_MAX_PS 9000

// AXI response codes.
`define ATO_RESP_OKAY 2'b00
`define ATO_RESP_SLVERR 2'b10

`endif

// file: logic/ato_pkg.sv
`default_nettype none

package ato_pkg;

    // Phase of the termination switch.
    typedef enum logic [2:0] {
        ATO_PARK = 3'b000,
        ATO_ON_WAIT = 3'b001,
        ATO_ON_RAMP = 3'b010,
        ATO_NOMINAL = 3'b011,
        ATO_OFF_WAIT = 3'b100,
        ATO_OFF_RAMP = 3'b101
    } ato_phase_e;

    // Termination setting as applied to the pads.
    typedef struct packed {
        logic [2:0] code;
        logic moving;
        logic at_nominal;
    } ato_term_s;

endpackage : ato_pkg

`default_nettype wire

// file: logic/ato_top.sv
// What this block does
// (R1) Use asynchronous termination timing whenever the DLL is bypassed.
// (R2) Act on the termination pin directly, with no additive or parity latency.
// (R3) Switching follows only the turn-on and turn-off min/max windows.
// (R4) After pin sampled high, leave park no earlier than turn-on minimum.
// (R5) Reach nominal termination by the turn-on maximum.
// (R6) Turn-on bounds count from the edge sampling the pin high.
// (R7) After pin sampled low, leave nominal no earlier than turn-off minimum.
// (R8) Be back at park termination by the turn-off maximum.
// (R9) Write-triggered write termination is never performed with DLL bypassed.
// (R10) While the pin is low, apply the park termination value.
// (R11) Controller programs nominal strength in mode register one bits 10:8.
// (R12) Controller programs park strength in mode register five bits 8:6.
// (R13) Sample the pin on rising edges; windows start at the registered change.
`include "ato_map.svh"
`timescale 1ns/1ps
`default_nettype none

module ato_top #(
    parameter int CNT_W = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic term_pin,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output ato_pkg::ato_term_s term_out
);

    // Window bounds in cycles: minimums round up, maximums round down, at least one.
    localparam int P = `ATO_CLK_PERIOD_PS;
    localparam int ON_MIN_RAW = (`ATO_ON_MIN_PS + P - 1) / P;
    localparam int ON_MAX_RAW = `ATO_ON_MAX_PS / P;
    localparam int OFF_MIN_RAW = (`ATO_OFF_MIN_PS + P - 1) / P;
    localparam int OFF_MAX_RAW = `ATO_OFF_MAX_PS / P;
    localparam logic [CNT_W-1:0] ON_MIN = CNT_W'((ON_MIN_RAW < 1) ? 1 : ON_MIN_RAW);
    localparam logic [CNT_W-1:0] ON_MAX = CNT_W'((ON_MAX_RAW < 1) ? 1 : ON_MAX_RAW);
    localparam logic [CNT_W-1:0] OFF_MIN = CNT_W'((OFF_MIN_RAW < 1) ? 1 : OFF_MIN_RAW);
    localparam logic [CNT_W-1:0] OFF_MAX = CNT_W'((OFF_MAX_RAW < 1) ? 1 : OFF_MAX_RAW);

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage and bus state.

    logic [1:0] ctrl_reg;
    logic [2:0] nom_code_reg;
    logic [2:0] park_code_reg;
    logic [3:0] awaddr_reg;
    logic aw_held_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic w_held_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // Pin synchroniser and termination state.
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic pin_last_reg;
    ato_pkg::ato_phase_e phase_reg;
    ato_pkg::ato_phase_e phase_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    ato_pkg::ato_term_s term_reg;
    ato_pkg::ato_term_s term_next;

    // Address decode, used for both write and read channels.
    function automatic logic ofs_mapped(input logic [3:0] a);
        ofs_mapped = (a == `ATO_CTRL_OFS) || (a == `ATO_MODE_ONE_OFS) ||
                     (a == `ATO_MODE_FIVE_OFS) || (a == `ATO_STATUS_OFS);
    endfunction : ofs_mapped

    ////////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data are held independently, then committed.

    wire aw_take = s_axi_awvalid && !aw_held_reg;
    wire w_take = s_axi_wvalid && !w_held_reg;
    wire wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
    wire wr_ctrl = wr_go && (awaddr_reg == `ATO_CTRL_OFS) && wstrb_reg[0];
    wire wr_one = wr_go && (awaddr_reg == `ATO_MODE_ONE_OFS) && wstrb_reg[1];
    wire wr_five = wr_go && (awaddr_reg == `ATO_MODE_FIVE_OFS);
    wire [31:0] five_word = {23'h0, park_code_reg, 6'h00};
    wire [31:0] five_merge = {16'h0000, wstrb_reg[1] ? wdata_reg[15:8] : five_word[15:8],
                              wstrb_reg[0] ? wdata_reg[7:0] : five_word[7:0]};
    wire dll_off = ctrl_reg[`ATO_CTRL_DLL_OFF_BIT];

    // Read data mux; the status word reflects the live termination.
    wire [31:0] rd_word =
        (s_axi_araddr == `ATO_CTRL_OFS) ? {30'h0, ctrl_reg} :
        (s_axi_araddr == `ATO_MODE_ONE_OFS) ? {21'h0, nom_code_reg, 8'h00} :
        (s_axi_araddr == `ATO_MODE_FIVE_OFS) ? five_word :
        (s_axi_araddr == `ATO_STATUS_OFS) ?
            {22'h0, !dll_off && ctrl_reg[`ATO_CTRL_WR_TERM_BIT], pin_sync_reg,
             term_reg.at_nominal, term_reg.moving, phase_reg, term_reg.code} :
        32'h0000_0000;
    wire rd_take = s_axi_arvalid && !rvalid_reg;

    // Bus handshake flops.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 4'h0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `ATO_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `ATO_RESP_OKAY;
        end else if (ce) begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held_reg <= 1'b0;
            end
            if (w_take) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held_reg <= 1'b0;
            end
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= ofs_mapped(awaddr_reg) ? `ATO_RESP_OKAY : `ATO_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (rd_take) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_word;
                rresp_reg <= ofs_mapped(s_axi_araddr) ? `ATO_RESP_OKAY : `ATO_RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // Configuration registers written by the controller.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= `ATO_CTRL_RST;
            nom_code_reg <= `ATO_CODE_RST;
            park_code_reg <= `ATO_CODE_RST;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl_reg <= wdata_reg[1:0];
            end
            if (wr_one) begin
                nom_code_reg <= wdata_reg[`ATO_NOM_LSB +: 3]; // (R11)
            end
            if (wr_five) begin
                park_code_reg <= five_merge[`ATO_PARK_LSB +: 3]; // (R12)
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Termination switch. The pin goes straight from the synchroniser into the
    // window logic; no latency pipeline stands in between.

    // Two-flop synchroniser, then one flop remembering the last registered level.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            pin_last_reg <= 1'b0;
        end else if (ce) begin
            pin_meta_reg <= term_pin; // (R13)
            pin_sync_reg <= pin_meta_reg;
            pin_last_reg <= pin_sync_reg;
        end
    end

    wire rise = pin_sync_reg && !pin_last_reg; // (R2)
    wire fall = !pin_sync_reg && pin_last_reg;
    wire [CNT_W-1:0] cnt_inc = (cnt_reg == {CNT_W{1'b1}}) ? cnt_reg : cnt_reg + CNT_W'(1);

    // Phase sequencing; a change of level restarts the opposite window at once.
    always_comb begin
        phase_next = phase_reg;
        cnt_next = cnt_inc;
        if (!dll_off) begin
            phase_next = ato_pkg::ATO_PARK; // (R1)
        end else if (rise) begin
            phase_next = ato_pkg::ATO_ON_WAIT; // (R6)
            cnt_next = {{(CNT_W-1){1'b0}}, 1'b1};
        end else if (fall) begin
            phase_next = ato_pkg::ATO_OFF_WAIT; // (R13)
            cnt_next = {{(CNT_W-1){1'b0}}, 1'b1};
        end else begin
            unique case (phase_reg)
                ato_pkg::ATO_PARK: begin
                    phase_next = ato_pkg::ATO_PARK; // (R10)
                end
                ato_pkg::ATO_ON_WAIT: begin
                    if (cnt_reg >= ON_MAX) begin
                        phase_next = ato_pkg::ATO_NOMINAL; // (R5)
                    end else if (cnt_reg >= ON_MIN) begin
                        phase_next = ato_pkg::ATO_ON_RAMP; // (R4)
                    end
                end
                ato_pkg::ATO_ON_RAMP: begin
                    if (cnt_reg >= ON_MAX) begin
                        phase_next = ato_pkg::ATO_NOMINAL; // (R3)
                    end
                end
                ato_pkg::ATO_NOMINAL: begin
                    phase_next = ato_pkg::ATO_NOMINAL;
                end
                ato_pkg::ATO_OFF_WAIT: begin
                    if (cnt_reg >= OFF_MAX) begin
                        phase_next = ato_pkg::ATO_PARK; // (R8)
                    end else if (cnt_reg >= OFF_MIN) begin
                        phase_next = ato_pkg::ATO_OFF_RAMP; // (R7)
                    end
                end
                ato_pkg::ATO_OFF_RAMP: begin
                    if (cnt_reg >= OFF_MAX) begin
                        phase_next = ato_pkg::ATO_PARK;
                    end
                end
                default: begin
                    phase_next = ato_pkg::ATO_PARK;
                end
            endcase
        end
    end

    // Applied setting; write termination is never chosen here.
    wire nom_side = (phase_next == ato_pkg::ATO_ON_RAMP) ||
                    (phase_next == ato_pkg::ATO_NOMINAL) ||
                    (phase_next == ato_pkg::ATO_OFF_WAIT);
    wire ramp_next = (phase_next == ato_pkg::ATO_ON_RAMP) ||
                     (phase_next == ato_pkg::ATO_OFF_RAMP);
    assign term_next = {nom_side ? nom_code_reg : park_code_reg, ramp_next, // (R9)
                        phase_next == ato_pkg::ATO_NOMINAL};

    // Phase, counter and output flops.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_reg <= ato_pkg::ATO_PARK;
            cnt_reg <= '0;
            term_reg <= '0;
        end else if (ce) begin
            phase_reg <= phase_next;
            cnt_reg <= cnt_next;
            term_reg <= term_next;
        end
    end

    // Every output from a flop; the three ready outputs are inverted.
    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready = !w_held_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign term_out = term_reg;

endmodule : ato_top

`default_nettype wire

// file: sim/ato_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module ato_ctrl_model (
    input wire logic clk,
    input wire logic want,
    input wire logic [3:0] lag,
    output var logic term_pin = 1'b0
);
    logic [3:0] cnt_reg = 4'h0;

    // Follows the wanted level after lag extra cycles, changing just after an edge.
    always @(posedge clk) begin
        if (term_pin == want) begin
            cnt_reg <= 4'h0;
        end else if (cnt_reg >= lag) begin
            term_pin <= want;
            cnt_reg <= 4'h0;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
endmodule : ato_ctrl_model

`default_nettype wire

// file: sim/ato_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module ato_top_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic term_pin,
    input wire ato_pkg::ato_term_s term_out,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Every check samples on the rising edge and rests during reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////////////
    // Termination windows start at the edge that samples the new pin level.
    a_on_not_early: assert property (
        $rose(term_pin) |-> ($stable(term_out.code) && !term_out.moving
        && !term_out.at_nominal)[*4]) else $error("park left too early");
    a_on_by_max: assert property (
        $rose(term_pin) ##1 term_pin[*4] |-> term_out.at_nominal && !term_out.moving)
        else $error("nominal not reached in time");
    a_off_not_early: assert property (
        $fell(term_pin) && term_out.at_nominal |-> term_out.at_nominal[*3]
        ##1 ($stable(term_out.code) && !term_out.moving))
        else $error("nominal left too early");
    a_off_by_max: assert property (
        $fell(term_pin) ##1 (!term_pin)[*4] |-> !term_out.at_nominal && !term_out.moving)
        else $error("park not reached in time");
    a_park_while_low: assert property (
        (!term_pin)[*6] |-> !term_out.at_nominal && !term_out.moving)
        else $error("park not held while pin low");
    a_nominal_while_high: assert property (
        term_pin[*6] |-> term_out.at_nominal) else $error("nominal not held while pin high");

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus answers.
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");
    a_resp_clears: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write response stuck");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
        && !s_axi_arready) else $error("read data late");
    a_read_clears: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
        && s_axi_arready) else $error("read data stuck");

    // Main scenarios seen.
    c_turn_on: cover property ($rose(term_pin) ##1 term_pin[*4]);
    c_turn_off: cover property ($fell(term_pin) ##1 (!term_pin)[*4]);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : ato_top_monitor

bind ato_top ato_top_monitor mon (.*);

`default_nettype wire

// file: sim/ato_top_tb.sv
`include "ato_map.svh"
`timescale 1ns/1ps
`default_nettype none

module ato_top_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic want = 1'b0;
    logic [3:0] lag = 4'h0;
    wire term_pin;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd;
    ato_pkg::ato_term_s term_out;
    int fails = 0;
    int n_tests = 0;

    // Design, controller model and clock.
    ato_top #(.CNT_W(8)) dut (.*);
    ato_ctrl_model ctrl (.clk(clk), .want(want), .lag(lag), .term_pin(term_pin));
    initial forever #12.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    // Comparison and closing report.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    // Bus cycles hold each channel until its own handshake edge.
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        int i;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 50 && !(s_axi_bvalid && s_axi_bready); i++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (i == 50) begin
            fails++;
            end_of_test();
        end
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a);
        int i;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 50 && !(s_axi_rvalid && s_axi_rready); i++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (i == 50) begin
            fails++;
            end_of_test();
        end
    endtask : axi_read

    // Moves the pin and counts cycles until the termination settles.
    task automatic term_step(input logic lvl, input logic [3:0] lg, input logic [2:0] code);
        int n;
        @(posedge clk);
        want <= lvl;
        lag <= lg;
        for (n = 0; n < 40 && term_pin !== lvl; n++) @(negedge clk);
        if (n == 40) begin
            fails++;
            end_of_test();
        end
        // Turn-off counts as settled only once the park code is back in place.
        for (n = 0; n < 40 && !(term_out.at_nominal === lvl && !term_out.moving
                && (lvl || term_out.code === code)); n++)
            @(negedge clk);
        check("settle cycles", 32'(n), 32'h0000_0004);
        check("applied code", 32'(term_out.code), 32'(code));
        if (n == 40) end_of_test();
    endtask : term_step

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        axi_read(`ATO_CTRL_OFS);
        check("ctrl reset", rd, 32'(`ATO_CTRL_RST));
        axi_read(`ATO_MODE_ONE_OFS);
        check("mode one reset", rd, 32'h0000_0000);
        check("term reset", 32'(term_out), 32'h0000_0000);
        $display("test reset values done");
        axi_write(`ATO_MODE_ONE_OFS, 32'h0000_0500, 4'h2);
        axi_read(`ATO_MODE_ONE_OFS);
        check("nominal code", rd, 32'h0000_0500);
        axi_write(`ATO_MODE_FIVE_OFS, 32'h0000_00C0, 4'h3);
        axi_read(`ATO_MODE_FIVE_OFS);
        check("park code", rd, 32'h0000_00C0);
        axi_write(4'h2, 32'h0000_FFFF, 4'hF);
        check("unmapped write", 32'(rsp), 32'(`ATO_RESP_SLVERR));
        axi_read(4'h2);
        check("unmapped read", 32'(rsp), 32'(`ATO_RESP_SLVERR));
        axi_write(`ATO_STATUS_OFS, 32'hFFFF_FFFF, 4'hF);
        check("status write", 32'(rsp), 32'(`ATO_RESP_OKAY));
        $display("test registers done");
        for (int k = 0; k < 2; k++) begin
            term_step(1'b1, 4'(k * 5), 3'h5);
            term_step(1'b0, 4'(k * 5), 3'h3);
        end
        $display("test termination windows done");
        axi_write(`ATO_CTRL_OFS, 32'h0000_0003, 4'h1);
        term_step(1'b1, 4'h0, 3'h5);
        axi_read(`ATO_STATUS_OFS);
        check("status pin and write term", 32'(rd[9:8]), 32'h0000_0001);
        term_step(1'b0, 4'h0, 3'h3);
        $display("test write termination done");
        // With the loop not bypassed a short pulse must leave park untouched.
        axi_write(`ATO_CTRL_OFS, 32'h0000_0000, 4'h1);
        want <= 1'b1;
        repeat (3) @(posedge clk);
        want <= 1'b0;
        for (int n = 0; n < 8; n++) begin
            @(negedge clk);
            check("park with loop on", 32'(term_out), 32'h0000_000C);
        end
        $display("test park with loop on done");
        end_of_test();
    end

    // Cuts a hang short.
    initial begin
        #1000000;
        fails++;
        end_of_test();
    end
endmodule : ato_top_tb

`default_nettype wire
